// *** inc/i2c_slave_regs.svh ***
// register-access i2c slave: address, timing and field constants
// assumes inclusion by bare name from the package and the slave core file
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH
`define SLAVE_ADDR_HIGH   5'h13
`define DIR_BIT           0
`define BIT_COUNT_LAST    4'h7
`define BIT_COUNT_ACK     4'h8
`define BIT_COUNT_ZERO    4'h0
`define BIT_COUNT_PRE     4'hf
`define BIT_STEP          4'h1
`define LOW_BIT_TOP       4'h6
`define HIGH_BIT_TOP      4'he
`define BYTE_ZERO         8'h00
`define WORD_ZERO         16'h0000
`define SYNC_IDLE         3'h7
`define PTR_STEP          8'h01
`endif

// *** inc/i2c_slave_pkg.sv ***
// register-access i2c slave: shared types
// assumes the constants header is on the include path
`include "i2c_slave_regs.svh"
package i2c_slave_pkg;
  // transaction phase of the slave
  typedef enum logic [2:0]
  {
    PH_IDLE   = 3'b000,
    PH_DEVADR = 3'b001,
    PH_PTR    = 3'b010,
    PH_WRDATA = 3'b011,
    PH_RDDATA = 3'b100,
    PH_IGNORE = 3'b101
  } phase_type;
endpackage

// *** inc/line_sync_if.sv ***
// interface carrying the filtered bus line levels and edges
// assumes one clock domain, filled by the line filter module
interface line_sync_if;
  logic scl_level;   // filtered clock line
  logic sda_level;   // filtered data line
  logic scl_rise;    // clock line rose
  logic scl_fall;    // clock line fell
  logic start_seen;  // start or repeated start
  logic stop_seen;   // stop condition
  modport source (output scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
  modport sink   (input  scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

// *** core/line_filter.sv ***
// three-stage synchronisers for both lines, start/stop detection, rise/fall detection on the clock line
// assumes scl and sda are asynchronous pins, idle high
module line_filter
(
  input  wire logic   sys_clk,  // system clock
  input  wire logic   reset,    // async reset, active high
  input  wire logic   clk_en,   // freezes state when low
  input  wire logic   scl_in,   // raw clock pin
  input  wire logic   sda_in,   // raw data pin
  line_sync_if.source lines     // filtered levels and events
);
  typedef struct packed
  {
    logic [2:0] scl_sh;  // clock shift chain
    logic [2:0] sda_sh;  // data shift chain
    logic       scl;     // accepted clock level
    logic       sda;     // accepted data level
    logic       rise;    // clock rise pulse
    logic       fall;    // clock fall pulse
    logic       start;   // start pulse
    logic       stop;    // stop pulse
  } filt_state_type;

  filt_state_type state;       // registered state
  filt_state_type next_state;  // next state

  // ----------------------------------------
  // level acceptance and event detection
  // ----------------------------------------
  always_comb
  begin
    next_state        = state;
    next_state.scl_sh = {state.scl_sh[1:0], scl_in};
    next_state.sda_sh = {state.sda_sh[1:0], sda_in};
    next_state.rise   = 1'b0;
    next_state.fall   = 1'b0;
    next_state.start  = 1'b0;
    next_state.stop   = 1'b0;
    // change counts once stages two and three agree
    if (state.scl_sh[1] == state.scl_sh[2])
      next_state.scl = state.scl_sh[2];
    if (state.sda_sh[1] == state.sda_sh[2])
      next_state.sda = state.sda_sh[2];
    next_state.rise = next_state.scl & ~state.scl;
    next_state.fall = ~next_state.scl & state.scl;
    // data edges while clock stays high are conditions
    if (state.scl && next_state.scl)
    begin
      next_state.start = state.sda & ~next_state.sda;
      next_state.stop  = ~state.sda & next_state.sda;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state <= '{scl_sh: `SYNC_IDLE, sda_sh: `SYNC_IDLE, scl: 1'b1, sda: 1'b1, default: 1'b0};
    else if (clk_en)
      state <= next_state;
  end

  assign lines.scl_level  = state.scl;
  assign lines.sda_level  = state.sda;
  assign lines.scl_rise   = state.rise;
  assign lines.scl_fall   = state.fall;
  assign lines.start_seen = state.start;
  assign lines.stop_seen  = state.stop;
endmodule

// *** core/i2c_register_access_slave.sv ***
// i2c slave giving a bus master access to 16-bit internal registers
// assumes external pull-ups; register store lives outside behind reg_* ports
`include "i2c_slave_regs.svh"

// Overview of operation
// (R1) master sends start, address, write bit
// (R2) acknowledge matching address in ninth slot
// (R3) one-byte addresses, two-byte data items
// (R4) pointer byte follows address, acknowledged
// (R5) write data high byte first, each acknowledged
// (R6) pointer advances after each written pair
// (R7) release data line when transfer completes
// (R8) read begins with pointer write, repeated start
// (R9) read-direction address acknowledged after restart
// (R10) read data sent high byte first
// (R11) master acks reads; pointer advances per pair
// (R12) master not-acknowledge ends read, then stop
// (R13) address low bits from select pins
// (R14) all bytes shifted most significant first
// (R15) pointer values match three-wire mode registers
// (R16) ignore transactions with foreign address
// (R17) start or stop mid-pair aborts, discards
module i2c_register_access_slave
(
  input  wire logic        sys_clk,              // 125 mhz system clock
  input  wire logic        reset,                // async reset, active high
  input  wire logic        clk_en,               // freezes all state when low
  input  wire logic        scl_in,               // bus clock pin
  input  wire logic        sda_in,               // bus data pin level
  output logic             sda_out,              // data drive value, always low
  output logic             sda_oe_n,             // low while pulling data low
  input  wire logic        addr_select_pin_low,  // slave address bit 1
  input  wire logic        addr_select_pin_high, // slave address bit 2
  output logic [7:0]       reg_ptr,              // register pointer
  output logic [15:0]      reg_wdata,            // word to write
  output logic             reg_write,            // one-cycle write strobe
  output logic             reg_read,             // one-cycle read request
  input  wire logic [15:0] reg_rdata             // word read, sampled in the same cycle as reg_read
);
  line_sync_if lines ();  // filtered line events

  // ----------------------------------------
  // line synchronisation
  // ----------------------------------------
  line_filter u_filter
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .lines   (lines)
  );

  typedef struct packed
  {
    i2c_slave_pkg::phase_type phase;     // transaction phase
    logic [3:0]               bit_cnt;   // bit within byte, 8 is ack slot
    logic [7:0]               shift;     // byte shift register
    logic                     hi_done;   // high byte of pair received/sent
    logic [7:0]               hi_byte;   // held high byte of write pair
    logic [15:0]              tx_word;   // word being transmitted
    logic                     load_pend; // read data arrives this cycle
    logic                     ack_drive; // slave pulls data low
    logic                     tx_drive;  // slave drives a zero data bit
    logic                     master_na; // master refused a read byte
    logic [7:0]               ptr;       // register pointer
    logic [15:0]              wdata;     // write word
    logic                     wr;        // write strobe
    logic                     rd;        // read strobe
    logic                     oe_n;      // registered data enable
  } slave_state_type;

  slave_state_type state;       // registered state
  slave_state_type next_state;  // next state
  logic [6:0]      own_addr;    // slave address with pin bits

  // own address: fixed high part plus select pins
  assign own_addr = {`SLAVE_ADDR_HIGH, addr_select_pin_high, addr_select_pin_low}; // R13

  // ----------------------------------------
  // byte engine and transaction sequencing
  // ----------------------------------------
  always_comb
  begin
    next_state    = state;
    next_state.wr = 1'b0;
    next_state.rd = 1'b0;
    next_state.load_pend = 1'b0;
    // fetched word captured one cycle after request
    if (state.load_pend)
      next_state.tx_word = reg_rdata;
    // pointer steps the cycle after a pair is written
    if (state.wr)
      next_state.ptr = state.ptr + `PTR_STEP; // R6
    if (lines.start_seen)
    begin
      // start or restart: drop partial data, expect address
      next_state.phase     = i2c_slave_pkg::PH_DEVADR; // R17
      next_state.bit_cnt   = `BIT_COUNT_PRE;             // clock fall after start is no bit
      next_state.hi_done   = 1'b0;                     // R17
      next_state.ack_drive = 1'b0;
      next_state.tx_drive  = 1'b0;
    end
    else if (lines.stop_seen)
    begin
      // stop ends everything and frees the line
      next_state.phase     = i2c_slave_pkg::PH_IDLE; // R17
      next_state.hi_done   = 1'b0;
      next_state.ack_drive = 1'b0;                   // R7
      next_state.tx_drive  = 1'b0;
    end
    else if (state.phase != i2c_slave_pkg::PH_IDLE && state.phase != i2c_slave_pkg::PH_IGNORE)
    begin
      if (lines.scl_rise)
      begin
        // sample data; msb arrives first
        if (state.bit_cnt <= `BIT_COUNT_LAST)
          next_state.shift = {state.shift[6:0], lines.sda_level}; // R14
        else
          next_state.master_na = lines.sda_level; // R12
      end
      else if (lines.scl_fall)
      begin
        next_state.ack_drive = 1'b0;
        next_state.tx_drive  = 1'b0;
        if (state.bit_cnt == `BIT_COUNT_LAST)
        begin
          next_state.bit_cnt = `BIT_COUNT_ACK;
          case (state.phase)
            i2c_slave_pkg::PH_DEVADR:
            begin
              if (state.shift[7:1] == own_addr)
              begin
                next_state.ack_drive = 1'b1; // R2 R9
                if (state.shift[0] == `DIR_BIT)
                  next_state.phase = i2c_slave_pkg::PH_PTR; // R1 R8
                else
                begin
                  next_state.phase   = i2c_slave_pkg::PH_RDDATA; // R9
                  next_state.hi_done = 1'b0;
                  next_state.rd      = 1'b1;
                  next_state.load_pend = 1'b1;
                end
              end
              else
                next_state.phase = i2c_slave_pkg::PH_IGNORE; // R16
            end
            i2c_slave_pkg::PH_PTR:
            begin
              // pointer value used as is, shared with three-wire map
              next_state.ptr       = state.shift; // R4 R15
              next_state.ack_drive = 1'b1;        // R4
              next_state.phase     = i2c_slave_pkg::PH_WRDATA;
              next_state.hi_done   = 1'b0;
            end
            i2c_slave_pkg::PH_WRDATA:
            begin
              next_state.ack_drive = 1'b1; // R5
              if (!state.hi_done)
              begin
                next_state.hi_byte = state.shift; // R5
                next_state.hi_done = 1'b1;
              end
              else
              begin
                // complete pair: write, then advance
                next_state.wdata   = {state.hi_byte, state.shift}; // R3
                next_state.wr      = 1'b1;
                next_state.hi_done = 1'b0;
              end
            end
            i2c_slave_pkg::PH_RDDATA:
            begin
              // slave sent this byte: release for master ack
              next_state.hi_done = ~state.hi_done; // R10
              if (state.hi_done)
              begin
                // low byte out: step and fetch next word during the ack slot
                next_state.ptr       = state.ptr + `PTR_STEP; // R11
                next_state.rd        = 1'b1;
                next_state.load_pend = 1'b1;
              end
            end
            default:
              next_state.phase = i2c_slave_pkg::PH_IGNORE;
          endcase
        end
        else if (state.bit_cnt == `BIT_COUNT_ACK)
        begin
          next_state.bit_cnt = `BIT_COUNT_ZERO;
          if (state.phase == i2c_slave_pkg::PH_RDDATA)
          begin
            if (state.master_na)
              next_state.phase = i2c_slave_pkg::PH_IGNORE; // R12 R7
            else
            begin
              // first bit of next byte, word already fetched
              next_state.tx_drive = ~(state.hi_done ? state.tx_word[7]
                                                    : state.tx_word[15]); // R10
            end
          end
        end
        else
        begin
          next_state.bit_cnt = state.bit_cnt + `BIT_STEP;
          // next bit to send, high byte first then low
          if (state.phase == i2c_slave_pkg::PH_RDDATA)
            next_state.tx_drive = ~(state.hi_done
                                    ? state.tx_word[`LOW_BIT_TOP - state.bit_cnt]
                                    : state.tx_word[`HIGH_BIT_TOP - state.bit_cnt]); // R10 R14
        end
      end
    end
    next_state.oe_n = ~(next_state.ack_drive | next_state.tx_drive);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state <= '{phase: i2c_slave_pkg::PH_IDLE, bit_cnt: `BIT_COUNT_ZERO, shift: `BYTE_ZERO,
                 hi_byte: `BYTE_ZERO, tx_word: `WORD_ZERO, ptr: `BYTE_ZERO,
                 wdata: `WORD_ZERO, oe_n: 1'b1, default: 1'b0};
    else if (clk_en)
      state <= next_state;
  end

  assign sda_out   = 1'b0;
  assign sda_oe_n  = state.oe_n;
  assign reg_ptr   = state.ptr;
  assign reg_wdata = state.wdata;
  assign reg_write = state.wr;
  assign reg_read  = state.rd;
endmodule

// *** sim/i2c_slave_sva.sv ***
// concurrent checks on the register-access i2c slave ports
// assumes one clock domain and is attached by the bind at the foot
module i2c_slave_sva
(
  input wire logic        sys_clk,              // system clock
  input wire logic        reset,                // async reset, active high
  input wire logic        clk_en,               // state enable
  input wire logic        scl_in,               // bus clock pin
  input wire logic        sda_in,               // bus data line level
  input wire logic        sda_out,              // data drive value
  input wire logic        sda_oe_n,             // low while pulling data low
  input wire logic        addr_select_pin_low,  // address strap bit 1
  input wire logic        addr_select_pin_high, // address strap bit 2
  input wire logic [7:0]  reg_ptr,              // register pointer
  input wire logic [15:0] reg_wdata,            // word to write
  input wire logic        reg_write,            // write strobe
  input wire logic        reg_read,             // read strobe
  input wire logic [15:0] reg_rdata             // word read
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic [7:0] wr_ptr; // pointer of the last written pair
  // remember where the last pair landed
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      wr_ptr <= 8'h00;
    else if (reg_write)
      wr_ptr <= reg_ptr;
  end
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  chk_drive_zero: assert property (sda_out == 1'b0 && (sda_oe_n || !sda_in))
    else $error("data drive value not low");
  chk_write_single: assert property (reg_write |=> !reg_write)
    else $error("write strobe longer than one cycle");
  chk_read_single: assert property (reg_read |=> !reg_read)
    else $error("read strobe longer than one cycle");
  chk_write_acked: assert property (reg_write |-> ##[0:20] !sda_oe_n)
    else $error("written pair not acknowledged");
  chk_ptr_advance: assert property (reg_write |-> ##[1:120] (reg_ptr == 8'(wr_ptr + 8'h01)))
    else $error("pointer did not step after a pair");
  chk_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data drive changed while clock high");
  chk_stop_release: assert property (scl_in && $past(scl_in) && $rose(sda_in) |=> sda_oe_n [*8])
    else $error("data line held after stop");
  chk_read_ptr_hold: assert property (reg_read |=> $stable(reg_ptr))
    else $error("pointer moved during register fetch");
endmodule

bind i2c_register_access_slave i2c_slave_sva u_i2c_slave_sva
(
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin_low(addr_select_pin_low),
  .addr_select_pin_high(addr_select_pin_high), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
);

// *** sim/i2c_master_model.sv ***
// i2c bus master model: clock line and open-drain data line
// assumes a pull-up on data, so a released line reads high
module i2c_master_model
(
  input  wire logic sys_clk,  // pacing clock
  input  wire logic sda_line, // resolved data line
  output logic      scl,      // bus clock, high outside frames
  output logic      sda_drv   // 0 pulls data low, 1 releases
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: both lines high
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // half bus period, far above the slave sync latency
  task automatic hp;
    repeat (40) @(negedge sys_clk);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_cond;
    sda_drv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    scl = 1'b0;
    hp;
  endtask
  // stop: data rises while clock high
  task automatic stop_cond;
    sda_drv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b1;
    hp;
  endtask
  // one clock pulse, line sampled at the end of the high phase
  task automatic clk_bit(input logic b, output logic r);
    sda_drv = b;
    hp;
    scl = 1'b1;
    hp;
    r   = sda_line;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], q[i]);
    clk_bit(ack_in, ack);
  endtask
endmodule

// *** sim/i2c_register_access_slave_tb.sv ***
// self-checking bench for the register-access i2c slave
// assumes the master model and the bound checker are compiled alongside
module i2c_register_access_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk   = 1'b0;  // 125 mhz clock
  logic        reset     = 1'b1;  // held for 20 cycles
  logic        pin_lo    = 1'b0;  // address strap bit 1
  logic        pin_hi    = 1'b0;  // address strap bit 2
  logic [15:0] reg_rdata = 16'h0000; // register store answer
  logic [7:0]  salt      = 8'h00; // random read pattern key
  logic        scl, sda_drv, sda_out, sda_oe_n, reg_write, reg_read, ack;
  logic [7:0]  reg_ptr, q;
  logic [15:0] reg_wdata;
  logic [23:0] exp_q[$];          // expected pointer and word per write
  wire         sda_line = sda_drv & (sda_oe_n | sda_out); // pull-up wire
  int          fail_count = 0;
  int          samples_checked = 0;
  always #4 sys_clk = ~sys_clk;
  i2c_register_access_slave u_i2c_register_access_slave
  (
    .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin_low(pin_lo),
    .addr_select_pin_high(pin_hi), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
  );
  i2c_master_model u_i2c_master_model
  (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
  );
  // register store: word is a fixed mix of the pointer
  always @(negedge sys_clk)
    reg_rdata <= {reg_ptr ^ salt, ~reg_ptr};
  // --------------------------------------------------------------
  // checking and verdict
  // --------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // each write strobe takes the oldest expectation
  always @(negedge sys_clk)
  begin
    if (reg_write === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(24'h000001, 24'h000000);
      else
        check({reg_ptr, reg_wdata}, exp_q.pop_front());
    end
  end
  // --------------------------------------------------------------
  // bus transactions
  // --------------------------------------------------------------
  task automatic put(input logic [7:0] d, input logic exp_ack);
    u_i2c_master_model.xfer(d, 1'b1, q, ack);
    check({23'h0, ack}, {23'h0, exp_ack});
  endtask
  task automatic head(input logic [7:0] p);
    u_i2c_master_model.start_cond;
    put({5'h13, pin_hi, pin_lo, 1'b0}, 1'b0);
    put(p, 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input int n);
    logic [15:0] w;
    head(p);
    for (int k = 0; k < n; k++)
    begin
      w = 16'($urandom);
      exp_q.push_back({8'(p + 8'(k)), w});
      put(w[15:8], 1'b0);
      put(w[7:0], 1'b0);
    end
    u_i2c_master_model.stop_cond;
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] e;
    head(p);
    u_i2c_master_model.start_cond;
    put({5'h13, pin_hi, pin_lo, 1'b1}, 1'b0);
    for (int k = 0; k < 2 * n; k++)
    begin
      e = 8'(p + 8'(k / 2));
      u_i2c_master_model.xfer(8'hff, k == 2 * n - 1, q, ack);
      check({16'h0, q}, {16'h0, k[0] ? ~e : e ^ salt});
    end
    u_i2c_master_model.stop_cond;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h50fb160b));
    salt = 8'($urandom);
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int s = 0; s < 4; s++)
    begin
      {pin_hi, pin_lo} = 2'(s);
      wr(8'($urandom), 2);
    end
    rd(8'($urandom), 2);
    rd(8'hff, 2);
    head(8'h40);
    put(8'($urandom), 1'b0);
    u_i2c_master_model.stop_cond;
    head(8'h50);
    put(8'($urandom), 1'b0);
    wr(8'hfe, 2);
    u_i2c_master_model.start_cond;
    put({5'h13, ~pin_hi, pin_lo, 1'b0}, 1'b1);
    put(8'h22, 1'b1);
    u_i2c_master_model.stop_cond;
    repeat (10) @(negedge sys_clk);
    check({23'h0, exp_q.size() == 0}, 24'h000001);
    give_verdict;
  end
  // watchdog: about two and a half times the expected run length
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    give_verdict;
  end
endmodule
